/* File: free_running_timer_counter_bench.sv */
// self-checking bench for the free-running timer core
// assumes the AHB-Lite slave is the only one, so hreadyout is the bus hready
`timescale 1ns/100ps
module free_running_timer_counter_bench;
  import frt_pkg::*;
  logic hclk, hresetn, hsel, hwrite, halt_mode, cpu_irq_mask, ext_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, timer_irq;
  int fails, cmp_count;
  frt_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_timer_clock_pin(ext_pin), .cpu_irq_mask(cpu_irq_mask),
    .halt_mode(halt_mode), .timer_irq(timer_irq));
  frt_ext_src #(.HALF(4)) src (.hclk(hclk), .pin(ext_pin));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic print_verdict;
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, m, s, e);
    end
  endtask
  // waits for hready high at a rising edge, bounded
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= FRT_HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(a, 1'b0, 32'h00000000);
    check(rd, e, m);
  endtask
  // halted since reset, so the count is still the reset value
  task automatic t_reset;
    rd_chk(FRT_OFF_CNT_HIGH, 32'h000000FF, "reset high");
    rd_chk(FRT_OFF_CNT_LOW, 32'h000000FC, "reset low");
    rd_chk(FRT_OFF_CTRL_TWO, 32'h00000000, "ctrl two reset");
    rd_chk(FRT_OFF_STATUS, 32'h00000000, "status reset");
  endtask
  // exactly 8*d running clocks give 8 ticks whatever the prescaler phase
  task automatic t_divide;
    logic [1:0] sel [3];
    int dv [3];
    sel = '{FRT_SEL_DIV2, FRT_SEL_DIV4, FRT_SEL_DIV8};
    dv = '{2, 4, 8};
    for (int i = 0; i < 3; i++) begin
      wr(FRT_OFF_CTRL_TWO, {30'h0, sel[i]});
      wr(FRT_OFF_CNT_LOW, 32'h00000000);
      rd_chk(FRT_OFF_CNT_LOW, 32'h000000FC, "forced low");
      @(posedge hclk);
      halt_mode <= 1'b0;
      repeat (8 * dv[i]) @(posedge hclk);
      halt_mode <= 1'b1;
      rd_chk(FRT_OFF_CNT_LOW, 32'h00000004, "divided count");
      rd_chk(FRT_OFF_CNT_HIGH, 32'h00000000, "divided high");
      rd_chk(FRT_OFF_CNT_LOW, 32'h00000004, "divided low");
    end
    rd_chk(FRT_OFF_STATUS, 32'h00000001, "unarmed writes keep flag");
  endtask
  // pin pulses give one selected edge each, for both edge choices
  task automatic t_ext;
    halt_mode <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      wr(FRT_OFF_CTRL_TWO, {29'h0, e[0], FRT_SEL_EXT});
      wr(FRT_OFF_ALT_LOW, 32'h00000000);
      rd_chk(FRT_OFF_CNT_HIGH, 32'h000000FF, "ext high");
      src.send(2);
      rd_chk(FRT_OFF_ALT_HIGH, 32'h000000FF, "repeat high");
      rd_chk(FRT_OFF_ALT_LOW, 32'h000000FC, "latched low");
      rd_chk(FRT_OFF_ALT_LOW, 32'h000000FE, "live low");
      rd_chk(FRT_OFF_CNT_LOW, 32'h000000FE, "main equals alt");
      src.send(2);
      rd_chk(FRT_OFF_ALT_HIGH, 32'h00000000, "wrapped high");
      rd_chk(FRT_OFF_ALT_LOW, 32'h00000000, "wrapped low");
    end
  endtask
  task automatic t_irq;
    cpu_irq_mask <= 1'b1;
    wr(FRT_OFF_CTRL_ONE, 32'h00000001);
    repeat (3) @(posedge hclk);
    check({31'h0, timer_irq}, 32'h00000000, "masked irq");
    cpu_irq_mask <= 1'b0;
    repeat (3) @(posedge hclk);
    check({31'h0, timer_irq}, 32'h00000001, "pending irq");
    rd_chk(FRT_OFF_STATUS, 32'h00000001, "arm");
    rd_chk(FRT_OFF_ALT_LOW, 32'h00000000, "alt access");
    rd_chk(FRT_OFF_STATUS, 32'h00000001, "alt keeps flag");
    rd_chk(FRT_OFF_CNT_LOW, 32'h00000000, "main low access");
    rd_chk(FRT_OFF_STATUS, 32'h00000000, "flag cleared");
    repeat (3) @(posedge hclk);
    check({31'h0, timer_irq}, 32'h00000000, "irq dropped");
  endtask
  task automatic t_map;
    wr(FRT_OFF_CMP2_HIGH, 32'h00000055);
    rd_chk(FRT_OFF_CMP2_HIGH, 32'h00000000, "cmp2 write only");
    wr(8'h40, 32'h000000AA);
    rd_chk(8'h40, 32'h00000000, "unmapped");
    check({31'h0, hresp}, 32'h00000000, "okay");
  endtask
  initial begin
    fails = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    halt_mode = 1'b1;
    cpu_irq_mask = 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_divide();
    t_ext();
    t_irq();
    t_map();
    print_verdict();
  end
endmodule

/* File: frt_ext_src.sv */
// model of the external clock source that drives the timer clock pin
// assumes the bench calls send() and the pin is sampled on hclk rising edges
`timescale 1ns/100ps
module frt_ext_src #(
  parameter int HALF = 4
) (
  input wire logic hclk, // core clock
  output logic pin // external timer clock
);
  initial pin = 1'b0;
  // pin stands low between bursts; spacing never below HALF clocks
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (HALF) @(posedge hclk);
      pin <= 1'b1;
      repeat (HALF) @(posedge hclk);
      pin <= 1'b0;
    end
    repeat (HALF) @(posedge hclk);
  endtask
endmodule

/* File: frt_pkg.sv */
// constants, register map and field layout of the free-running timer core
// assumes a 32-bit AHB-Lite register bus, one word per register
package frt_pkg;
  localparam int unsigned FRT_AW = 8;
  localparam logic [FRT_AW-1:0] FRT_OFF_CTRL_ONE = 8'h00;
  localparam logic [FRT_AW-1:0] FRT_OFF_CTRL_TWO = 8'h04;
  localparam logic [FRT_AW-1:0] FRT_OFF_STATUS = 8'h08;
  localparam logic [FRT_AW-1:0] FRT_OFF_CNT_HIGH = 8'h0C;
  localparam logic [FRT_AW-1:0] FRT_OFF_CNT_LOW = 8'h10;
  localparam logic [FRT_AW-1:0] FRT_OFF_ALT_HIGH = 8'h14;
  localparam logic [FRT_AW-1:0] FRT_OFF_ALT_LOW = 8'h18;
  localparam logic [FRT_AW-1:0] FRT_OFF_CMP2_HIGH = 8'h1C;
  localparam logic [FRT_AW-1:0] FRT_OFF_CMP2_LOW = 8'h20;

  localparam logic [15:0] FRT_CNT_RESET = 16'hFFFC;
  localparam logic [15:0] FRT_CNT_MAX = 16'hFFFF;

  // control one: bit 0 overflow interrupt enable
  localparam int unsigned FRT_C1_OVF_IE_BIT = 0;
  // control two: bits 1:0 clock select, bit 2 external edge select
  localparam int unsigned FRT_C2_SEL_LSB = 0;
  localparam int unsigned FRT_C2_EDGE_BIT = 2;
  // status: bit 0 overflow, bit 1 second capture, bit 2 second compare
  localparam int unsigned FRT_ST_OVF_BIT = 0;
  localparam int unsigned FRT_ST_CAP2_BIT = 1;
  localparam int unsigned FRT_ST_CMP2_BIT = 2;

  localparam logic [1:0] FRT_SEL_DIV4 = 2'h0;
  localparam logic [1:0] FRT_SEL_DIV2 = 2'h1;
  localparam logic [1:0] FRT_SEL_DIV8 = 2'h2;
  localparam logic [1:0] FRT_SEL_EXT = 2'h3;
  localparam logic [2:0] FRT_MASK_DIV2 = 3'h1;
  localparam logic [2:0] FRT_MASK_DIV4 = 3'h3;
  localparam logic [2:0] FRT_MASK_DIV8 = 3'h7;

  localparam logic [1:0] FRT_HTRANS_NONSEQ = 2'h2;
  localparam logic FRT_HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic ovf_irq_en;
  } frt_ctrl_one_t;

  typedef struct packed {
    logic ext_edge_rise;
    logic [1:0] clk_sel;
  } frt_ctrl_two_t;

  typedef struct packed {
    logic fire;
    logic [FRT_AW-1:0] addr;
  } frt_access_t;
endpackage

/* File: frt_timer.sv */
// free-running 16-bit timer counting core with an AHB-Lite register slave
// assumes pins synchronous to hclk; processor mask and halt come from the core
//
// Contract
// - sixteen-bit up-counter readable as two bytes
// - internal tick is clock divided 2, 4, 8
// - full cycle is 65536 ticks of prescaler
// - reset and only reload value is FFFC
// - low byte write forces counter to FFFC
// - alternate pair same value, never clears overflow
// - high byte read latches matching low byte
// - latched low holds until low byte read
// - after sequence, low read returns live byte
// - wrap FFFF to 0000 sets overflow flag
// - interrupt needs enable and clear processor mask
// - status read then main low access clears
// - wait mode leaves counter running
// - halt freezes counter, resumes held value
// - select 11 picks external pin, edge selectable
// - external pin sampled on the core clock
// - unbonded pin reads as constant one
// - second capture, compare flags held at zero
// - instances share nothing, stay count aligned
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module frt_timer #(
  parameter bit EXT_PIN_BONDED = 1'b1
) (
  input wire logic hclk, // core clock, 250 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic ext_timer_clock_pin, // external timer clock
  input wire logic cpu_irq_mask, // processor interrupt mask, high masks
  input wire logic halt_mode, // processor halted
  output logic timer_irq // overflow interrupt request
);
  import frt_pkg::*;

  function automatic logic div_tick(input logic [1:0] sel, input logic [2:0] presc);
    logic [2:0] mask;
    mask = FRT_MASK_DIV4;
    if (sel == FRT_SEL_DIV2) begin
      mask = FRT_MASK_DIV2;
    end else if (sel == FRT_SEL_DIV8) begin
      mask = FRT_MASK_DIV8;
    end
    div_tick = ((presc & mask) == mask);
  endfunction

  function automatic logic hit(input frt_access_t acc, input logic [FRT_AW-1:0] off);
    hit = acc.fire && (acc.addr == off);
  endfunction

  logic rd_pend_r;
  logic [FRT_AW-1:0] rd_addr_r;
  logic wr_pend_r;
  logic [FRT_AW-1:0] wr_addr_r;
  logic [31:0] hrdata_r;
  frt_ctrl_one_t ctrl_one_r;
  frt_ctrl_two_t ctrl_two_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [2:0] presc_r;
  logic pin_r;
  logic pin_prev_r;
  logic ovf_flag_r;
  logic ovf_flag_nxt;
  logic clr_arm_r;
  logic clr_arm_nxt;
  logic [7:0] lat_r;
  logic lat_valid_r;
  logic irq_r;

  // bus side decode
  wire take = hsel && hready && htrans[1];
  wire frt_access_t rd_acc = '{fire: rd_pend_r, addr: rd_addr_r};
  wire frt_access_t wr_acc = '{fire: wr_pend_r, addr: wr_addr_r};
  wire rd_hi = hit(rd_acc, FRT_OFF_CNT_HIGH) || hit(rd_acc, FRT_OFF_ALT_HIGH);
  wire rd_main_lo = hit(rd_acc, FRT_OFF_CNT_LOW);
  wire rd_alt_lo = hit(rd_acc, FRT_OFF_ALT_LOW);
  wire rd_lo = rd_main_lo || rd_alt_lo;
  wire rd_status = hit(rd_acc, FRT_OFF_STATUS);
  wire wr_main_lo = hit(wr_acc, FRT_OFF_CNT_LOW);
  wire wr_lo = wr_main_lo || hit(wr_acc, FRT_OFF_ALT_LOW);
  wire wr_c1 = hit(wr_acc, FRT_OFF_CTRL_ONE);
  wire wr_c2 = hit(wr_acc, FRT_OFF_CTRL_TWO);
  wire main_lo_access = rd_main_lo || wr_main_lo;

  // counter clocking
  wire pin_eff = EXT_PIN_BONDED ? ext_timer_clock_pin : 1'b1;
  wire ext_sel = (ctrl_two_r.clk_sel == FRT_SEL_EXT);
  wire ext_edge = ctrl_two_r.ext_edge_rise ? (pin_r && !pin_prev_r) :
                  (!pin_r && pin_prev_r);
  wire int_tick = div_tick(ctrl_two_r.clk_sel, presc_r);
  // only halt gates counting; wait mode has no input here on purpose
  wire tick = !halt_mode && (ext_sel ? ext_edge : int_tick);
  wire ovf_set = tick && !wr_lo && (cnt_r == FRT_CNT_MAX);

  // a low write beats a tick in the same cycle
  assign cnt_nxt = wr_lo ? FRT_CNT_RESET :
                   tick ? cnt_r + 16'h0001 : cnt_r;

  // arming needs the flag seen set; any main low access disarms
  assign clr_arm_nxt = (rd_status && ovf_flag_r) ? 1'b1 :
                       main_lo_access ? 1'b0 : clr_arm_r;
  // set wins over clear; alt low and unarmed access never clear
  assign ovf_flag_nxt = ovf_set || (ovf_flag_r && !(main_lo_access && clr_arm_r));

  wire [7:0] low_view = lat_valid_r ? lat_r : cnt_r[7:0];
  wire [31:0] status_word = (32'(ovf_flag_r) << FRT_ST_OVF_BIT) |
                            (32'(1'b0) << FRT_ST_CAP2_BIT) |
                            (32'(1'b0) << FRT_ST_CMP2_BIT);
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (rd_addr_r == FRT_OFF_CTRL_ONE) begin
      rd_val = 32'(ctrl_one_r) << FRT_C1_OVF_IE_BIT;
    end else if (rd_addr_r == FRT_OFF_CTRL_TWO) begin
      rd_val = 32'(ctrl_two_r) << FRT_C2_SEL_LSB;
    end else if (rd_addr_r == FRT_OFF_STATUS) begin
      rd_val = status_word;
    end else if (rd_addr_r == FRT_OFF_CNT_HIGH || rd_addr_r == FRT_OFF_ALT_HIGH) begin
      rd_val = 32'(cnt_r[15:8]);
    end else if (rd_addr_r == FRT_OFF_CNT_LOW || rd_addr_r == FRT_OFF_ALT_LOW) begin
      rd_val = 32'(low_view);
    end
    // second compare words are write-only and read as zero
  end

  // reads take one wait state so read data always reflects earlier writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_r <= 1'b0;
      rd_addr_r <= '0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      rd_pend_r <= take && !hwrite;
      wr_pend_r <= take && hwrite;
      if (take) begin
        rd_addr_r <= haddr[FRT_AW-1:0];
        wr_addr_r <= haddr[FRT_AW-1:0];
      end
      if (rd_pend_r) begin
        hrdata_r <= rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_one_r <= '0;
      ctrl_two_r <= '0;
    end else begin
      if (wr_c1) begin
        ctrl_one_r <= frt_ctrl_one_t'(hwdata[FRT_C1_OVF_IE_BIT]);
      end
      if (wr_c2) begin
        ctrl_two_r.clk_sel <= hwdata[FRT_C2_SEL_LSB +: 2];
        ctrl_two_r.ext_edge_rise <= hwdata[FRT_C2_EDGE_BIT];
      end
    end
  end

  // no shared prescaler: equal instances stay aligned from reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= FRT_CNT_RESET;
      presc_r <= 3'h0;
      pin_r <= 1'b1;
      pin_prev_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      if (!halt_mode) begin
        presc_r <= presc_r + 3'h1;
      end
      // single-clock sampling; each pin level must be held for at least one clock
      pin_r <= pin_eff;
      pin_prev_r <= pin_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_flag_r <= 1'b0;
      clr_arm_r <= 1'b0;
      lat_r <= 8'h00;
      lat_valid_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ovf_flag_r <= ovf_flag_nxt;
      clr_arm_r <= clr_arm_nxt;
      if (rd_hi && !lat_valid_r) begin
        lat_r <= cnt_r[7:0];
        lat_valid_r <= 1'b1;
      end else if (rd_lo) begin
        lat_valid_r <= 1'b0;
      end
      // stays pending in the flag until enable and mask allow it
      irq_r <= ovf_flag_r && ctrl_one_r.ovf_irq_en && !cpu_irq_mask;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = !rd_pend_r;
  assign hresp = FRT_HRESP_OKAY;
  assign timer_irq = irq_r;

  property p_load_value;
    @(posedge hclk) disable iff (!hresetn)
    wr_lo |=> (cnt_r == FRT_CNT_RESET);
  endproperty
  a_load_value: assert property (p_load_value) else $error("low write did not reload");

  property p_count_up;
    @(posedge hclk) disable iff (!hresetn)
    (tick && !wr_lo) |=> (cnt_r == $past(cnt_r) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not advance");

  property p_div2_gap;
    @(posedge hclk) disable iff (!hresetn)
    // halt in the tick cycle or the next one freezes the prescaler, so both must run
    (int_tick && ctrl_two_r.clk_sel == FRT_SEL_DIV2 && !halt_mode && !wr_c2)
      ##1 (!halt_mode && !wr_c2) |-> !int_tick ##1 int_tick;
  endproperty
  a_div2_gap: assert property (p_div2_gap) else $error("divide by two spacing wrong");

  property p_halt_hold;
    @(posedge hclk) disable iff (!hresetn)
    (halt_mode && !wr_lo) |=> $stable(cnt_r);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("counter moved in halt");

  property p_ovf_set;
    @(posedge hclk) disable iff (!hresetn)
    (tick && !wr_lo && cnt_r == FRT_CNT_MAX) |=> (ovf_flag_r && cnt_r == 16'h0000);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("wrap did not set overflow");

  property p_alt_keeps;
    @(posedge hclk) disable iff (!hresetn)
    (rd_alt_lo && ovf_flag_r) |=> ovf_flag_r;
  endproperty
  a_alt_keeps: assert property (p_alt_keeps) else $error("alternate low cleared flag");

  property p_clear;
    @(posedge hclk) disable iff (!hresetn)
    (main_lo_access && clr_arm_r && !ovf_set) |=> !ovf_flag_r;
  endproperty
  a_clear: assert property (p_clear) else $error("armed low access did not clear");

  property p_unarmed;
    @(posedge hclk) disable iff (!hresetn)
    (main_lo_access && !clr_arm_r && ovf_flag_r) |=> ovf_flag_r;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed access cleared flag");

  property p_latch_hold;
    @(posedge hclk) disable iff (!hresetn)
    (lat_valid_r && !rd_lo) |=> (lat_valid_r && $stable(lat_r));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched low changed");

  property p_live_low;
    @(posedge hclk) disable iff (!hresetn)
    (rd_lo && !lat_valid_r) |=> (hrdata_r == 32'($past(cnt_r[7:0])));
  endproperty
  a_live_low: assert property (p_live_low) else $error("live low byte wrong");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    (ovf_flag_r && ctrl_one_r.ovf_irq_en && !cpu_irq_mask) |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_ext_step;
    @(posedge hclk) disable iff (!hresetn)
    (ext_sel && ext_edge && !halt_mode && !wr_lo) |=> (cnt_r == $past(cnt_r) + 16'h0001);
  endproperty
  a_ext_step: assert property (p_ext_step) else $error("external edge missed");

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
    (take && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

  property p_write_ready;
    @(posedge hclk) disable iff (!hresetn)
    (take && hwrite) |=> hreadyout;
  endproperty
  a_write_ready: assert property (p_write_ready) else $error("write got a wait state");

  property p_latch_take;
    @(posedge hclk) disable iff (!hresetn)
    (rd_hi && !lat_valid_r) |=> (lat_valid_r && lat_r == $past(cnt_r[7:0]));
  endproperty
  a_latch_take: assert property (p_latch_take) else $error("high read missed latch");

  property p_high_data;
    @(posedge hclk) disable iff (!hresetn)
    rd_hi |=> (hrdata_r == 32'($past(cnt_r[15:8])));
  endproperty
  a_high_data: assert property (p_high_data) else $error("high byte data wrong");

  // the latch is spent by the read that returns it
  property p_latched_low;
    @(posedge hclk) disable iff (!hresetn)
    (rd_lo && lat_valid_r) |=> (hrdata_r == 32'($past(lat_r)) && !lat_valid_r);
  endproperty
  a_latched_low: assert property (p_latched_low) else $error("latched low not returned");

  property p_arm;
    @(posedge hclk) disable iff (!hresetn)
    (rd_status && ovf_flag_r) |=> clr_arm_r;
  endproperty
  a_arm: assert property (p_arm) else $error("status read did not arm clear");

  property p_flag_keep;
    @(posedge hclk) disable iff (!hresetn)
    (!ovf_set && !main_lo_access) |=> $stable(ovf_flag_r);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag moved without cause");

  property p_status_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_status |=> (hrdata_r == (32'($past(ovf_flag_r)) << FRT_ST_OVF_BIT));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status word wrong");

  property p_cmp2_read;
    @(posedge hclk) disable iff (!hresetn)
    (rd_pend_r && (rd_addr_r == FRT_OFF_CMP2_HIGH || rd_addr_r == FRT_OFF_CMP2_LOW))
      |=> (hrdata_r == 32'h0000_0000);
  endproperty
  a_cmp2_read: assert property (p_cmp2_read) else $error("compare two readable");

  property p_irq_off;
    @(posedge hclk) disable iff (!hresetn)
    !(ovf_flag_r && ctrl_one_r.ovf_irq_en && !cpu_irq_mask) |=> !timer_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while blocked");

  // with the pin selected the internal divider must not move the count
  property p_ext_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (ext_sel && !ext_edge && !wr_lo) |=> $stable(cnt_r);
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("count moved without edge");

  property p_idle_hold;
    @(posedge hclk) disable iff (!hresetn)
    (!tick && !wr_lo) |=> $stable(cnt_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved without tick");

  property p_presc_halt;
    @(posedge hclk) disable iff (!hresetn)
    halt_mode |=> $stable(presc_r);
  endproperty
  a_presc_halt: assert property (p_presc_halt) else $error("prescaler ran in halt");

  c_overflow: cover property (@(posedge hclk) disable iff (!hresetn) ovf_set);
  c_clear_seq: cover property (@(posedge hclk) disable iff (!hresetn)
    (rd_status && ovf_flag_r) ##[1:20] (main_lo_access && clr_arm_r));
  c_ext_tick: cover property (@(posedge hclk) disable iff (!hresetn) ext_sel && tick);
  c_latched: cover property (@(posedge hclk) disable iff (!hresetn) rd_lo && lat_valid_r);
  c_div2_run: cover property (@(posedge hclk) disable iff (!hresetn)
    int_tick && !halt_mode && ctrl_two_r.clk_sel == FRT_SEL_DIV2);
endmodule
